/* hdl/snsrc_params.svh */
// Constants for the serial nonvolatile SRAM save/restore controller
`ifndef SNSRC_PARAMS_SVH
`define SNSRC_PARAMS_SVH
`define SNSRC_CLK_NS 25
`define SNSRC_T_STORE_NS 1000000
`define SNSRC_T_RECALL_NS 500000
`define SNSRC_T_PUREC_NS 1000000
`define SNSRC_T_DELAY_NS 500
`define SNSRC_BUSY_HIGH_DRIVE_TIME_NS 200
`define SNSRC_POST_SAVE_RECOVERY_TIME_NS 5000
`define SNSRC_OPC_WRITE 8'h02
`define SNSRC_OPC_READ 8'h03
`define SNSRC_OPC_FREAD 8'h0b
`define SNSRC_OPC_STORE 8'h3c
`define SNSRC_OPC_RECALL 8'h60
`define SNSRC_OPC_ASEN 8'h59
`define SNSRC_OPC_ASDIS 8'h19
`define SNSRC_ERASE_VAL 8'hff
`define SNSRC_CELL_INIT 8'h00
`define SNSRC_LAST_ADDR 13'h1fff
`endif

/* hdl/snsrc_pkg.sv */
// Types for the serial nonvolatile SRAM save/restore controller
`default_nettype none
package snsrc_pkg;
  typedef enum logic [2:0] {SP_OPC, SP_ADDR, SP_DUMMY, SP_WDATA, SP_RDATA, SP_IGN} snsrc_spi_t;
  typedef enum logic [2:0] {
    OP_OFF, OP_IDLE, OP_DELAY, OP_STORE, OP_RECALL, OP_HIDRV, OP_RECOV
  } snsrc_op_t;
  typedef enum logic [2:0] {SRC_AUTO, SRC_SW, SRC_HW, SRC_PU, SRC_SWR} snsrc_src_t;
endpackage
`default_nettype wire

/* hdl/snsrc_core.sv */
// SPI slave, 8K x 8 SRAM and nonvolatile save/restore sequencer
`default_nettype none
`include "snsrc_params.svh"
// What this block does
// - Write: opcode, two address bytes, data
// - Burst write wraps to address zero
// - Read: opcode, two address bytes, data out
// - Fast read adds one dummy byte
// - Burst read wraps to address zero
// - Save erases nonvolatile, then programs it
// - Busy pin low, ready bit set
// - Power-down and pin saves need dirty flag
// - Save instruction always saves
// - Supply loss: block, conditional autosave
// - Instruction save blocks for save time
// - External pin low starts delayed save
// - Pin save blocks while pin low
// - Open-drain low, brief high, then release
// - Recovery block after busy pin rises from an instruction or pin save
// - Restore clears SRAM, then copies nonvolatile
// - Power-up always restores, access blocked
// - Autosave enable and disable, volatile
// - Autosave on, all cells zero initially
// - Unknown opcode ignored until next select
// - Mode from clock level at select
module snsrc_core
  import snsrc_pkg::*;
#(
  parameter int unsigned STORE_CYC = (`SNSRC_T_STORE_NS + `SNSRC_CLK_NS - 1) / `SNSRC_CLK_NS,
  parameter int unsigned RCL_CYC = (`SNSRC_T_RECALL_NS + `SNSRC_CLK_NS - 1) / `SNSRC_CLK_NS,
  parameter int unsigned PUR_CYC = (`SNSRC_T_PUREC_NS + `SNSRC_CLK_NS - 1) / `SNSRC_CLK_NS,
  parameter int unsigned LZ_CYC = (`SNSRC_POST_SAVE_RECOVERY_TIME_NS + `SNSRC_CLK_NS - 1) / `SNSRC_CLK_NS
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic cs_n_in,
  input wire logic sck_in,
  input wire logic si_in,
  input wire logic vcc_ok_in,
  input wire logic store_busy_request_pin_in,
  output logic store_busy_request_pin_out,
  output logic store_busy_request_pin_oe_out,
  output logic so_out,
  output logic so_oe_out,
  output logic ready_bit_out,
  output logic mem_blocked_out,
  output logic autosave_en_out,
  output logic spi_mode3_out
);
  localparam int unsigned DLY_CYC = (`SNSRC_T_DELAY_NS + `SNSRC_CLK_NS - 1) / `SNSRC_CLK_NS;
  localparam int unsigned HD_CYC = (`SNSRC_BUSY_HIGH_DRIVE_TIME_NS + `SNSRC_CLK_NS - 1) / `SNSRC_CLK_NS;
  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers: {vcc, busy pin, si, sck, cs_n}
  logic [4:0] sy1_r;
  logic [4:0] sy2_r;
  logic [4:0] dly_r;
  always_ff @(posedge mclk_in) begin
    sy1_r <= {vcc_ok_in, store_busy_request_pin_in, si_in, sck_in, cs_n_in};
    sy2_r <= sy1_r;
    dly_r <= sy2_r;
  end
  wire cs_n_q = sy2_r[0];
  wire sck_q = sy2_r[1];
  wire si_q = sy2_r[2];
  wire hsb_q = sy2_r[3];
  wire vcc_q = sy2_r[4];
  wire sck_rise = ~cs_n_q & sck_q & ~dly_r[1];
  wire sck_fall = ~cs_n_q & ~sck_q & dly_r[1];
  wire cs_fall = ~cs_n_q & dly_r[0];
  ////////////////////////////////////////////////////////////////////
  // Serial front end
  snsrc_spi_t sp_r, sp_nxt;
  snsrc_op_t op_r, op_nxt;
  snsrc_src_t src_r, src_nxt;
  logic [2:0] bit_r;
  logic [7:0] sh_r;
  logic [7:0] cmd_r;
  logic a1_r;
  logic [12:0] adr_r;
  logic [7:0] tx_r;
  logic so_r, so_oe_r, mode3_r;
  logic [7:0] sram_r [0:8191];
  logic [7:0] nv_r [0:8191];
  wire blocked = op_r != OP_IDLE;
  wire byte_done = sck_rise & (bit_r == 3'h7);
  wire [7:0] rx = {sh_r[6:0], si_q};
  wire [12:0] a_now = (sp_r == SP_ADDR) ? {adr_r[4:0], rx} : adr_r;
  wire in_opc = byte_done & (sp_r == SP_OPC);
  wire is_rd = (rx == `SNSRC_OPC_READ) | (rx == `SNSRC_OPC_FREAD);
  wire is_wr = rx == `SNSRC_OPC_WRITE;
  wire sw_st = in_opc & (rx == `SNSRC_OPC_STORE);
  wire sw_rc = in_opc & (rx == `SNSRC_OPC_RECALL);
  wire as_on = in_opc & (rx == `SNSRC_OPC_ASEN);
  wire as_off = in_opc & (rx == `SNSRC_OPC_ASDIS);
  wire adr_last = byte_done & (sp_r == SP_ADDR) & a1_r;
  // dummy byte before fast read data
  wire go_rd = byte_done & ((adr_last & (cmd_r == `SNSRC_OPC_READ)) | (sp_r == SP_DUMMY)
               | (sp_r == SP_RDATA));
  wire wr_en = byte_done & (sp_r == SP_WDATA) & ~blocked;
  always_comb begin
    sp_nxt = sp_r;
    if (byte_done) begin
      case (sp_r)
        // anything but a memory command idles
        SP_OPC: sp_nxt = (is_rd | is_wr) ? SP_ADDR : SP_IGN;
        SP_ADDR: begin
          if (a1_r) begin
            sp_nxt = (cmd_r == `SNSRC_OPC_FREAD) ? SP_DUMMY
                   : (cmd_r == `SNSRC_OPC_READ) ? SP_RDATA : SP_WDATA;
          end
        end
        SP_DUMMY: sp_nxt = SP_RDATA;
        default: sp_nxt = sp_r;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || cs_n_q) begin
      sp_r <= SP_OPC;
      bit_r <= 3'h0;
      a1_r <= 1'b0;
    end else if (sck_rise) begin
      sp_r <= sp_nxt;
      bit_r <= bit_r + 3'h1;
      sh_r <= rx;
      if (in_opc) cmd_r <= rx;
      if (byte_done && sp_r == SP_ADDR) a1_r <= 1'b1;
    end
  end
  // mode from clock level at select
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) mode3_r <= 1'b0;
    else if (cs_fall) mode3_r <= sck_q;
  end
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) adr_r <= 13'h0000;
    else if (go_rd || wr_en) adr_r <= a_now + 13'h0001;
    else if (byte_done && sp_r == SP_ADDR) adr_r <= a_now;
  end
  // Output shifts on falling edges; next byte is fetched a half clock early
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      tx_r <= 8'h00;
      so_r <= 1'b0;
    end else if (go_rd) begin
      tx_r <= sram_r[a_now];
    end else if (sck_fall && sp_r == SP_RDATA) begin
      so_r <= tx_r[7];
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end
  // output stays off when busy or ignored
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) so_oe_r <= 1'b0;
    else so_oe_r <= ~cs_n_q & (sp_r == SP_RDATA) & ~blocked;
  end

  ////////////////////////////////////////////////////////////////////
  // Save / restore sequencer
  logic [31:0] cnt_r;
  logic [14:0] wk_r;
  logic dirty_r, as_r;
  wire tdone = cnt_r == 32'h0;
  wire wdone = wk_r[14];
  wire [12:0] wk_idx = wk_r[12:0];
  wire run = (op_r == OP_STORE) | (op_r == OP_RECALL);
  wire run_nxt = (op_nxt == OP_STORE) | (op_nxt == OP_RECALL);
  wire op_start = run_nxt & ~run;

  always_comb begin
    op_nxt = op_r;
    src_nxt = src_r;
    case (op_r)
      OP_OFF: begin
        if (vcc_q) begin
          op_nxt = OP_RECALL;
          src_nxt = SRC_PU;
        end
      end
      OP_IDLE: begin
        if (!vcc_q) begin
          op_nxt = (as_r & dirty_r) ? OP_STORE : OP_OFF;
          src_nxt = SRC_AUTO;
        end else if (sw_st) begin
          op_nxt = OP_STORE;
          src_nxt = SRC_SW;
        end else if (sw_rc) begin
          op_nxt = OP_RECALL;
          src_nxt = SRC_SWR;
        end else if (!hsb_q) begin
          op_nxt = OP_DELAY;
          src_nxt = SRC_HW;
        end
      end
      OP_DELAY: if (tdone) op_nxt = dirty_r ? OP_STORE : OP_IDLE;
      OP_STORE: if (tdone && wdone) op_nxt = (src_r == SRC_AUTO) ? OP_OFF : OP_HIDRV;
      OP_RECALL: if (tdone && wdone) op_nxt = OP_HIDRV;
      OP_HIDRV: begin
        if (tdone) op_nxt = (src_r == SRC_SW || src_r == SRC_HW) ? OP_RECOV : OP_IDLE;
      end
      OP_RECOV: if (tdone && hsb_q) op_nxt = OP_IDLE;
      default: op_nxt = OP_OFF;
    endcase
  end
  // recovery restarts while the pin is held low
  wire cnt_ld = (op_nxt != op_r) | ((op_r == OP_RECOV) & ~hsb_q);
  wire [31:0] cnt_val = (op_nxt == OP_STORE) ? STORE_CYC
                      : (op_nxt == OP_RECALL) ? ((src_nxt == SRC_PU) ? PUR_CYC : RCL_CYC)
                      : (op_nxt == OP_DELAY) ? DLY_CYC
                      : (op_nxt == OP_HIDRV) ? HD_CYC : LZ_CYC;

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      op_r <= OP_OFF;
      src_r <= SRC_PU;
      cnt_r <= 32'h0;
    end else begin
      op_r <= op_nxt;
      src_r <= src_nxt;
      if (cnt_ld) cnt_r <= cnt_val - 32'h1;
      else if (!tdone) cnt_r <= cnt_r - 32'h1;
    end
  end
  // Walk: low half clears (restore) or erases (save), high half copies, then holds
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) wk_r <= 15'h0000;
    else if (op_start) wk_r <= 15'h0000;
    else if (run && !wdone) wk_r <= wk_r + 15'h0001;
  end
  // Set wins over clear: a write in the start cycle keeps the flag
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) dirty_r <= 1'b0;
    else if (wr_en) dirty_r <= 1'b1;
    else if (op_start) dirty_r <= 1'b0;
  end

  // volatile autosave enable, on after reset
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) as_r <= 1'b1;
    else if (as_on) as_r <= 1'b1;
    else if (as_off) as_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // Arrays: one walk port, one serial write port
  // restore clears then copies
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) sram_r <= '{default: `SNSRC_CELL_INIT};
    else if (op_r == OP_RECALL && !wdone)
      sram_r[wk_idx] <= wk_r[13] ? nv_r[wk_idx] : `SNSRC_CELL_INIT;
    else if (wr_en) sram_r[adr_r] <= rx;
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) nv_r <= '{default: `SNSRC_CELL_INIT};
    else if (op_r == OP_STORE && !wdone)
      nv_r[wk_idx] <= wk_r[13] ? sram_r[wk_idx] : `SNSRC_ERASE_VAL;
  end

  ////////////////////////////////////////////////////////////////////
  // Registered outputs
  logic hsb_o_r, hsb_oe_r, rdy_r, blk_r;
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      hsb_o_r <= 1'b0;
      hsb_oe_r <= 1'b0;
      rdy_r <= 1'b0;
      blk_r <= 1'b1;
    end else begin
      hsb_oe_r <= run_nxt | (op_nxt == OP_HIDRV);
      hsb_o_r <= op_nxt == OP_HIDRV;
      rdy_r <= run_nxt;
      blk_r <= op_nxt != OP_IDLE;
    end
  end
  assign store_busy_request_pin_out = hsb_o_r;
  assign store_busy_request_pin_oe_out = hsb_oe_r;
  assign so_out = so_r;
  assign so_oe_out = so_oe_r;
  assign ready_bit_out = rdy_r;
  assign mem_blocked_out = blk_r;
  assign autosave_en_out = as_r;
  assign spi_mode3_out = mode3_r;

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  AST_WR_WRAP: assert property (wr_en && adr_r == `SNSRC_LAST_ADDR |=> adr_r == 13'h0)
    else $error("write address did not wrap");
  AST_RD_WRAP: assert property (go_rd && a_now == `SNSRC_LAST_ADDR |=> adr_r == 13'h0)
    else $error("read address did not wrap");
  AST_NO_DATA_BUSY: assert property (blocked |=> !so_oe_out)
    else $error("data driven while busy");
  AST_BUSY_PIN: assert property (run |-> hsb_oe_r && !hsb_o_r && rdy_r)
    else $error("busy not shown");
  AST_SW_STORE: assert property (op_r == OP_IDLE && vcc_q && sw_st |=> op_r == OP_STORE)
    else $error("instruction save not started");
  AST_PIN_SKIP: assert property (op_r == OP_DELAY && tdone && !dirty_r |=> op_r == OP_IDLE)
    else $error("clean pin save not skipped");
  AST_PIN_REQ: assert property (op_r == OP_IDLE && vcc_q && !hsb_q && !sw_st && !sw_rc
    |=> op_r == OP_DELAY ##[1:30] op_r != OP_DELAY)
    else $error("pin request not delayed");
  AST_HIGH_DRV: assert property (op_r == OP_HIDRV |-> hsb_oe_r && hsb_o_r)
    else $error("pin not driven high after busy");
  AST_PWRDN: assert property (op_r == OP_IDLE && !vcc_q && as_r && dirty_r
    |=> op_r == OP_STORE && src_r == SRC_AUTO)
    else $error("autosave missing");
  AST_PWRUP: assert property (op_r == OP_OFF && vcc_q |=> op_r == OP_RECALL ##1 mem_blocked_out)
    else $error("power-up restore missing");
  AST_RECOV: assert property ($fell(hsb_oe_r) && $past(src_r) == SRC_SW |-> blk_r[*8])
    else $error("recovery block too short");
  AST_MODE: assert property (cs_fall |=> mode3_r == $past(sck_q))
    else $error("mode not captured");
  AST_IGN: assert property (sp_r == SP_IGN |=> !so_oe_out)
    else $error("output on after bad opcode");
  CVR_BURST_RD: cover property (go_rd && a_now == `SNSRC_LAST_ADDR);
  CVR_PIN_SAVE: cover property (op_r == OP_DELAY ##1 op_r == OP_STORE);
  CVR_SW_RECALL: cover property (sw_rc && op_r == OP_IDLE);
  CVR_AUTOSAVE: cover property (op_r == OP_STORE && src_r == SRC_AUTO);
endmodule // snsrc_core
`default_nettype wire

/* bench/snsrc_spi_mst.sv */
// Behavioural SPI master and busy/request pin driver
`default_nettype none
module snsrc_spi_mst (
  input wire logic mclk_in,
  input wire logic so_in,
  output logic cs_n_out,
  output logic sck_out,
  output logic si_out,
  output logic req_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic m3_r;
  initial begin
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    si_out = 1'b0;
    req_n_out = 1'b1;
    m3_r = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge mclk_in);
  endtask
  task automatic cs_begin(input logic m3);
    m3_r = m3;
    sck_out = m3;
    tick(4);
    cs_n_out = 1'b0;
    tick(4);
  endtask
  // 5 MHz clock, well under limit
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck_out = 1'b0;
      si_out = tx[i];
      tick(4);
      sck_out = 1'b1;
      tick(4);
      rx[i] = so_in;
    end
  endtask
  task automatic cs_end();
    tick(4);
    sck_out = m3_r;
    tick(4);
    cs_n_out = 1'b1;
    // Released line must not hold its last value
    si_out = ~si_out;
    tick(8);
  endtask
  task automatic pin_req(input logic low);
    req_n_out = ~low;
  endtask
endmodule // snsrc_spi_mst
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking bench for the save/restore controller
`default_nettype none
`include "snsrc_params.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_n, vcc_ok, cs_n, sck, si, req_n, pin_o, pin_oe, so, so_oe;
  logic rdy, blk, asen, m3, hi_seen;
  wire logic pin_w;
  wire logic so_w;
  logic [7:0] rb;
  int fail_count = 0;
  int num_checks = 0;
  // Open-drain wire with pull-up
  assign pin_w = ((pin_oe && !pin_o) || !req_n) ? 1'b0 : 1'b1;
  // Undriven data line shows the inverse, never a held value
  assign so_w = so_oe ? so : ~so;
  // Short save/restore counts keep the run small
  snsrc_core #(.STORE_CYC(20), .RCL_CYC(20), .PUR_CYC(20)) i_dut (
    .mclk_in(mclk), .rst_n_in(rst_n), .cs_n_in(cs_n), .sck_in(sck), .si_in(si),
    .vcc_ok_in(vcc_ok), .store_busy_request_pin_in(pin_w),
    .store_busy_request_pin_out(pin_o), .store_busy_request_pin_oe_out(pin_oe),
    .so_out(so), .so_oe_out(so_oe), .ready_bit_out(rdy), .mem_blocked_out(blk),
    .autosave_en_out(asen), .spi_mode3_out(m3));
  snsrc_spi_mst i_mst (.mclk_in(mclk), .so_in(so_w), .cs_n_out(cs_n), .sck_out(sck),
    .si_out(si), .req_n_out(req_n));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Bounded wait for access to reopen; notes any brief high drive
  task automatic wait_free();
    int n;
    n = 0;
    hi_seen = 1'b0;
    while (blk !== 1'b0) begin
      @(negedge mclk);
      if (pin_oe === 1'b1 && pin_o === 1'b1) hi_seen = 1'b1;
      n++;
      if (n > 40000) begin
        chk("wait", 8'h01, 8'h00);
        finish_test();
      end
    end
  endtask
  task automatic addr(input logic [12:0] a);
    i_mst.xbyte({3'h0, a[12:8]}, rb);
    i_mst.xbyte(a[7:0], rb);
  endtask
  task automatic wr2(input logic [12:0] a, input logic [7:0] d0, input logic [7:0] d1);
    i_mst.cs_begin(1'b0);
    i_mst.xbyte(`SNSRC_OPC_WRITE, rb);
    addr(a);
    i_mst.xbyte(d0, rb);
    i_mst.xbyte(d1, rb);
    i_mst.cs_end();
  endtask
  task automatic rd2(input logic md, input logic [7:0] opc, input logic [12:0] a,
                     input logic [7:0] e0, input logic [7:0] e1);
    logic [7:0] r0;
    i_mst.cs_begin(md);
    i_mst.xbyte(opc, rb);
    addr(a);
    if (opc == `SNSRC_OPC_FREAD) i_mst.xbyte(8'h00, rb);
    i_mst.xbyte(8'h00, r0);
    i_mst.xbyte(8'h00, rb);
    chk("so_oe", {7'h0, so_oe}, 8'h01);
    chk("mode3", {7'h0, m3}, {7'h0, md});
    i_mst.cs_end();
    chk("rd0", r0, e0);
    chk("rd1", rb, e1);
  endtask
  task automatic cmd(input logic [7:0] opc);
    i_mst.cs_begin(1'b0);
    i_mst.xbyte(opc, rb);
    i_mst.cs_end();
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    vcc_ok = 1'b1;
    wait_cyc(10);
    chk("asen", {7'h0, asen}, 8'h01);
    rst_n = 1'b1;
    wait_cyc(2);
    chk("blk", {7'h0, blk}, 8'h01);
    wait_free();
    wr2(13'h1fff, 8'ha5, 8'h5a);
    rd2(1'b0, `SNSRC_OPC_READ, 13'h1fff, 8'ha5, 8'h5a);
    rd2(1'b1, `SNSRC_OPC_FREAD, 13'h0000, 8'h5a, 8'h00);
    i_mst.cs_begin(1'b0);
    i_mst.xbyte(8'ha7, rb);
    i_mst.xbyte(`SNSRC_OPC_WRITE, rb);
    addr(13'h0000);
    i_mst.xbyte(8'h99, rb);
    chk("so_oe", {7'h0, so_oe}, 8'h00);
    i_mst.cs_end();
    cmd(`SNSRC_OPC_STORE);
    wait_cyc(4);
    chk("rdy", {7'h0, rdy}, 8'h01);
    chk("pin", {6'h0, pin_oe, pin_o}, 8'h02);
    wr2(13'h0000, 8'h11, 8'h22);
    wait_free();
    chk("hi", {7'h0, hi_seen}, 8'h01);
    rd2(1'b0, `SNSRC_OPC_READ, 13'h0000, 8'h5a, 8'h00);
    i_mst.pin_req(1'b1);
    wait_cyc(60);
    chk("rdy", {7'h0, rdy}, 8'h00);
    i_mst.pin_req(1'b0);
    wait_free();
    wr2(13'h0001, 8'h33, 8'h44);
    i_mst.pin_req(1'b1);
    wait_cyc(60);
    chk("rdy", {7'h0, rdy}, 8'h01);
    chk("blk", {7'h0, blk}, 8'h01);
    i_mst.pin_req(1'b0);
    wait_free();
    wr2(13'h0001, 8'h77, 8'h77);
    cmd(`SNSRC_OPC_RECALL);
    wait_cyc(4);
    chk("rdy", {7'h0, rdy}, 8'h01);
    wait_free();
    rd2(1'b0, `SNSRC_OPC_READ, 13'h0001, 8'h33, 8'h44);
    cmd(`SNSRC_OPC_STORE);
    wait_cyc(4);
    chk("rdy", {7'h0, rdy}, 8'h01);
    wait_free();
    cmd(`SNSRC_OPC_ASDIS);
    chk("asen", {7'h0, asen}, 8'h00);
    cmd(`SNSRC_OPC_ASEN);
    chk("asen", {7'h0, asen}, 8'h01);
    wr2(13'h0002, 8'h55, 8'h66);
    // Protect-bit rewrite after a failed save lies outside this block
    vcc_ok = 1'b0;
    wait_cyc(40);
    chk("rdy", {7'h0, rdy}, 8'h01);
    chk("blk", {7'h0, blk}, 8'h01);
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
